// *** inc/tcp_pkg.sv ***
// Shared constants, register map and helper functions of the three-channel PWM.
package tcp_pkg;

  // ==========================================================================
  // Widths and sizes.
  localparam int TCP_ADDR_W = 8;
  localparam int TCP_DATA_W = 32;
  localparam int TCP_STRB_W = 4;
  localparam int TCP_NUM_CH = 3;
  localparam int TCP_CNT_W = 10;
  localparam int TCP_PRE_W = 3;

  // ==========================================================================
  // Register indexes; the byte address is four times the index.
  localparam logic [5:0] TCP_IDX_EN_CTRL = 6'h10;
  localparam logic [5:0] TCP_IDX_DUTY_HI_CTRL = 6'h11;
  localparam logic [5:0] TCP_IDX_PRD_DIV_SEL = 6'h12;
  localparam logic [5:0] TCP_IDX_DUTY_LO_WIN = 6'h13;
  localparam logic [5:0] TCP_IDX_PRD_LO = 6'h14;

  // ==========================================================================
  // Field positions.
  localparam int TCP_EN_LSB = 0;
  localparam int TCP_DUTY_HI_LSB = 0;
  localparam int TCP_PRD_HI_LSB = 6;
  localparam int TCP_DIV_LSB = 4;
  localparam int TCP_SEL_LSB = 0;

  // ==========================================================================
  // Reset values.
  localparam logic [2:0] TCP_EN_RST = 3'h0;
  localparam logic [9:0] TCP_DUTY_RST = 10'h000;
  localparam logic [1:0] TCP_PRD_HI_RST = 2'h0;
  localparam logic [7:0] TCP_PRD_LO_RST = 8'h00;
  localparam logic [1:0] TCP_DIV_RST = 2'h0;
  localparam logic [2:0] TCP_SEL_RST = 3'h0;

  // ==========================================================================
  // Helpers.
  // Terminal count of the prescaler for a divider select code.
  function automatic logic [2:0] tcp_div_last(input logic [1:0] sel);
    logic [2:0] r;
    r = 3'h0;
    case (sel)
      2'h0: r = 3'h0;
      2'h1: r = 3'h1;
      2'h2: r = 3'h3;
      default: r = 3'h7;
    endcase
    return r;
  endfunction : tcp_div_last

  // True when a channel-select code names a real channel.
  function automatic logic tcp_sel_ok(input logic [2:0] sel);
    return sel <= 3'h2;
  endfunction : tcp_sel_ok

endpackage : tcp_pkg

// *** rtl/tcp_prescaler.sv ***
// Shared clock prescaler that pulses a tick every 1, 2, 4 or 8 clocks.
`timescale 1ns/100ps
module tcp_prescaler (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic [1:0] div_sel,
  output logic tick
);
  import tcp_pkg::*;

  logic [TCP_PRE_W-1:0] cnt_q;
  logic [TCP_PRE_W-1:0] last;

  assign last = tcp_div_last(div_sel);

  // ==========================================================================
  // Divider counter.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 3'h0;
    end else if (!run || cnt_q >= last) begin
      cnt_q <= 3'h0;
    end else begin
      cnt_q <= cnt_q + 3'h1;
    end
  end

  // ==========================================================================
  // Tick output.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick <= 1'b0;
    end else begin
      tick <= run && (cnt_q >= last);
    end
  end

endmodule : tcp_prescaler

// *** rtl/tcp_channel.sv ***
// One PWM channel: buffered duty value and compare output.
`timescale 1ns/100ps
module tcp_channel #(
  parameter int CNT_W = 10
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic load,
  input wire logic en,
  input wire logic [CNT_W-1:0] cnt,
  input wire logic [CNT_W-1:0] duty_new,
  output logic [CNT_W-1:0] duty_act,
  output logic pwm_out
);
  import tcp_pkg::*;

  // ==========================================================================
  // Active duty, taken over at a period start and on every clock while no channel runs.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      duty_act <= '0;
    end else if (load) begin
      duty_act <= duty_new;
    end
  end

  // ==========================================================================
  // Compare output, held low while disabled.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_out <= 1'b0;
    end else begin
      // R12 - Compare with duty.
      pwm_out <= en && (cnt <= duty_act);
    end
  end

endmodule : tcp_channel

// *** rtl/tcp_pwm.sv ***
// Three-channel PWM with shared period counter, prescaler and APB registers.
//
// Summary of operation
// R1 - Three channels share one 10-bit period counter.
// R2 - One shared prescaler clocks the period counter.
// R3 - Each channel keeps its own 10-bit duty.
// R4 - New duty applies from the next period.
// R5 - Enable bits 2..0 gate channels, reset 0.
// R6 - Duty bits 9..8 packed in one control byte.
// R7 - Period bits 9..8 in bits 7..6, low separate.
// R8 - Divider field selects divide by 1,2,4,8.
// R9 - Select codes 0..2 pick channel, others none.
// R10 - Low duty window follows the channel select.
// R11 - Counter clears on period match, period+1 ticks.
// R12 - Output high while counter not above duty.
// R13 - Period captured when first channel enables.
// R14 - Software sets channel select before window access.
// R15 - Software configures divider, period, select, duty, enables; the testbench writes the low period, select and duties before the divider.
// R16 - Disabled output low; unused bits read zero.
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/100ps
module tcp_pwm (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [tcp_pkg::TCP_ADDR_W-1:0] paddr,
  input wire logic [tcp_pkg::TCP_DATA_W-1:0] pwdata,
  input wire logic [tcp_pkg::TCP_STRB_W-1:0] pstrb,
  output logic [tcp_pkg::TCP_DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [tcp_pkg::TCP_NUM_CH-1:0] pwm_out
);
  import tcp_pkg::*;

  // ==========================================================================
  // Register state.
  logic [TCP_NUM_CH-1:0] en_q;
  logic [TCP_CNT_W-1:0] duty_q [TCP_NUM_CH];
  logic [1:0] prd_hi_q;
  logic [7:0] prd_lo_q;
  logic [1:0] div_sel_q;
  logic [2:0] sel_q;
  logic [TCP_CNT_W-1:0] prd_act_q;
  logic [TCP_CNT_W-1:0] cnt_q;
  logic [TCP_CNT_W-1:0] duty_act [TCP_NUM_CH];
  logic [TCP_CNT_W-1:0] prd_full;
  logic run;
  logic tick;
  logic load;
  logic [5:0] idx;
  logic mapped;
  logic access;
  logic wr_en;
  logic [7:0] rd_byte;

  assign idx = paddr[7:2];
  assign access = psel && penable && !pready;
  assign wr_en = psel && penable && pready && pwrite && pstrb[0] && mapped;
  // R7 - Period assembly.
  assign prd_full = {prd_hi_q, prd_lo_q};
  assign run = |en_q;
  // R4 - Period start.
  assign load = !run || (tick && cnt_q == prd_act_q);

  // ==========================================================================
  // Address decode and read mux.
  always_comb begin
    mapped = paddr[1:0] == 2'h0;
    rd_byte = 8'h00;
    case (idx)
      // R16 - Unused bits zero.
      TCP_IDX_EN_CTRL: rd_byte = {5'h00, en_q};
      TCP_IDX_DUTY_HI_CTRL: rd_byte = {2'h0, duty_q[2][9:8], duty_q[1][9:8], duty_q[0][9:8]};
      TCP_IDX_PRD_DIV_SEL: rd_byte = {prd_hi_q, div_sel_q, 1'b0, sel_q};
      TCP_IDX_DUTY_LO_WIN: begin
        // R10 - Window read.
        if (tcp_sel_ok(sel_q)) begin
          rd_byte = duty_q[sel_q[1:0]][7:0];
        end
      end
      TCP_IDX_PRD_LO: rd_byte = prd_lo_q;
      default: mapped = 1'b0;
    endcase
  end

  // ==========================================================================
  // APB answer: one wait state, then a ready pulse.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= access;
      pslverr <= access && !mapped;
      if (access) begin
        prdata <= (pwrite || !mapped) ? 32'h0000_0000 : {24'h00_0000, rd_byte};
      end
    end
  end

  // ==========================================================================
  // Enable register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q <= TCP_EN_RST;
    end else if (wr_en && idx == TCP_IDX_EN_CTRL) begin
      // R5 - Channel enables.
      en_q <= pwdata[TCP_EN_LSB +: TCP_NUM_CH];
    end
  end

  // ==========================================================================
  // Duty registers.
  // R3 - Per-channel duty.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < TCP_NUM_CH; i++) begin
        duty_q[i] <= TCP_DUTY_RST;
      end
    end else if (wr_en) begin
      for (int i = 0; i < TCP_NUM_CH; i++) begin
        // R6 - High duty bits.
        if (idx == TCP_IDX_DUTY_HI_CTRL) begin
          duty_q[i][9:8] <= pwdata[TCP_DUTY_HI_LSB + 2*i +: 2];
        end
        // R9 - Select decode.
        if (idx == TCP_IDX_DUTY_LO_WIN && tcp_sel_ok(sel_q) && sel_q[1:0] == 2'(i)) begin
          duty_q[i][7:0] <= pwdata[7:0];
        end
      end
    end
  end

  // ==========================================================================
  // Period, divider and select registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prd_hi_q <= TCP_PRD_HI_RST;
      div_sel_q <= TCP_DIV_RST;
      sel_q <= TCP_SEL_RST;
      prd_lo_q <= TCP_PRD_LO_RST;
    end else if (wr_en) begin
      if (idx == TCP_IDX_PRD_DIV_SEL) begin
        prd_hi_q <= pwdata[TCP_PRD_HI_LSB +: 2];
        // R8 - Divider select.
        div_sel_q <= pwdata[TCP_DIV_LSB +: 2];
        sel_q <= pwdata[TCP_SEL_LSB +: 3];
      end
      if (idx == TCP_IDX_PRD_LO) begin
        prd_lo_q <= pwdata[7:0];
      end
    end
  end

  // ==========================================================================
  // Period capture.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prd_act_q <= '0;
    end else if (!run) begin
      // R13 - Latched once a channel runs.
      prd_act_q <= prd_full;
    end
  end

  // ==========================================================================
  // Shared prescaler.
  // R2 - One prescaler.
  tcp_prescaler u_pre (
    .pclk(pclk),
    .presetn(presetn),
    .run(run),
    .div_sel(div_sel_q),
    .tick(tick)
  );

  // ==========================================================================
  // Shared period counter.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
    end else if (!run) begin
      cnt_q <= '0;
    end else if (tick) begin
      // R11 - Clear on match.
      if (cnt_q == prd_act_q) begin
        cnt_q <= '0;
      end else begin
        cnt_q <= cnt_q + 10'h001;
      end
    end
  end

  // ==========================================================================
  // Channels.
  for (genvar g = 0; g < TCP_NUM_CH; g++) begin : g_ch
    // R1 - Common counter per channel.
    tcp_channel #(
      .CNT_W(TCP_CNT_W)
    ) u_ch (
      .pclk(pclk),
      .presetn(presetn),
      .load(load),
      .en(en_q[g]),
      .cnt(cnt_q),
      .duty_new(duty_q[g]),
      .duty_act(duty_act[g]),
      .pwm_out(pwm_out[g])
    );
  end

  // ==========================================================================
  // Checks.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_div8;
    (tick && run && div_sel_q == 2'h3) ##1 (div_sel_q == 2'h3 && run)[*7];
  endsequence

  sequence s_wr_win0;
    wr_en && idx == TCP_IDX_DUTY_LO_WIN && sel_q == 3'h0;
  endsequence

  sequence s_rd_win1;
    access && !pwrite && mapped && idx == TCP_IDX_DUTY_LO_WIN && sel_q == 3'h1;
  endsequence

  // R16 - Disabled output low.
  dis_low_a: assert property (en_q == 3'h0 |=> pwm_out == 3'h0) // R16
    else $error("Output high while all channels disabled.");

  // R12 - Compare output high.
  cmp_high_a: assert property (en_q[1] && cnt_q <= duty_act[1] |=> pwm_out[1]) // R12
    else $error("Channel output low although counter not above duty.");

  // R12 - Compare output low.
  cmp_low_a: assert property (!(en_q[1] && cnt_q <= duty_act[1]) |=> !pwm_out[1]) // R12
    else $error("Channel output high although counter above duty.");

  // R11 - Counter wrap.
  cnt_wrap_a: assert property (run && tick && cnt_q == prd_act_q ##1 run |-> cnt_q == 10'h000) // R11
    else $error("Counter did not clear on period match.");

  // R11 - Counter bound.
  cnt_bound_a: assert property (run |-> cnt_q <= prd_act_q) // R11
    else $error("Counter beyond period.");

  // R4 - Duty held inside a period.
  duty_hold_a: assert property (!$past(load) |-> $stable(duty_act[0])) // R4
    else $error("Active duty changed mid period.");

  // R13 - Period held while running.
  prd_cap_a: assert property (run && $stable(run) && !$rose(run) |=> $stable(prd_act_q)) // R13
    else $error("Period changed while running.");

  // R8 - Divide by eight spacing.
  div_eight_a: assert property (s_div8 |=> tick) // R8
    else $error("Divide by eight tick missing.");

  // R8 - No tick in the clock right after a divide by eight tick.
  div_gap_a: assert property ((tick && div_sel_q == 2'h3) ##1 (div_sel_q == 2'h3) |-> !tick) // R8
    else $error("Divide by eight ticked early.");

  // R10 - Window write reaches channel 0.
  win_wr_a: assert property (s_wr_win0 |=> duty_q[0][7:0] == $past(pwdata[7:0])) // R10
    else $error("Window write missed channel 0.");

  // R9 - Unused select codes leave the channel 2 duty unchanged.
  sel_none_a: assert property (wr_en && idx == TCP_IDX_DUTY_LO_WIN && sel_q > 3'h2 |=> $stable(duty_q[2])) // R9
    else $error("Unused select code changed a duty.");

  // R5 - Enable write.
  en_wr_a: assert property (wr_en && idx == TCP_IDX_EN_CTRL |=> en_q == $past(pwdata[2:0])) // R5
    else $error("Enable register did not update.");

  // R4 - Duty loads at period start.
  duty_load_a: assert property (load |=> duty_act[0] == $past(duty_q[0])) // R4
    else $error("Active duty not taken at period start.");

  // R6 - High duty bits write.
  duty_hi_wr_a: assert property (wr_en && idx == TCP_IDX_DUTY_HI_CTRL |=> duty_q[2][9:8] == $past(pwdata[5:4])) // R6
    else $error("High duty bits did not update.");

  // R10 - Window read follows select.
  win_rd_a: assert property (s_rd_win1 |=> prdata[7:0] == $past(duty_q[1][7:0])) // R10
    else $error("Window read missed channel 1.");

  // R16 - Unused read bits zero.
  rd_zero_a: assert property (pready |-> prdata[31:8] == 24'h00_0000) // R16
    else $error("Upper read bits not zero.");

  // R16 - Disabled channel low.
  dis_ch2_a: assert property (!en_q[2] |=> !pwm_out[2]) // R16
    else $error("Disabled channel 2 output high.");

  // R11 - Counter steps on tick.
  cnt_step_a: assert property (run && tick && cnt_q != prd_act_q ##1 run |-> cnt_q == $past(cnt_q) + 10'h001) // R11
    else $error("Counter did not step on tick.");

  // R2 - Counter waits for tick.
  cnt_hold_a: assert property (run && !tick |=> $stable(cnt_q)) // R2
    else $error("Counter moved without a prescaler tick.");

endmodule : tcp_pwm

// *** sim/tb.sv ***
// Self-checking testbench of the three-channel PWM over its APB registers.
`timescale 1ns/100ps
module tb;
  import tcp_pkg::*;
  // ==========================================================================
  // Stimulus and design.
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [2:0] pwm_out;
  logic [31:0] rdat;
  logic rerr;
  int cnt [3];
  int errors = 0;
  int samples_checked = 0;

  always #12.5 pclk = ~pclk;

  tcp_pwm dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pwm_out(pwm_out));

  // ==========================================================================
  // Bus tasks and compares.
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_reg

  task automatic chk_cnt(input int got, input int exp);
    samples_checked++;
    if (got != exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_cnt

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk_reg(rdat, {24'h0, e});
  endtask : rdchk

  task automatic meas(input int cyc);
    cnt = '{0, 0, 0};
    repeat (cyc) begin
      @(posedge pclk);
      if ($isunknown(pwm_out)) begin
        chk_reg({29'h0, pwm_out}, 32'h0);
      end
      for (int i = 0; i < 3; i++) cnt[i] += (pwm_out[i] === 1'b1) ? 1 : 0;
    end
  endtask : meas

  task automatic results;
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results

  // ==========================================================================
  // Tests.
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 5; i++) rdchk(8'h40 + 8'(4 * i), 8'h00);
    wr(8'h40, 8'hff);
    rdchk(8'h40, 8'h07);
    wr(8'h40, 8'h00);
    wr(8'h44, 8'hff);
    rdchk(8'h44, 8'h3f);
    wr(8'h48, 8'hff);
    rdchk(8'h48, 8'hf7);
    apb(1'b0, 8'h54, 8'h00);
    chk_reg({31'h0, rerr}, 32'h1);
    pstrb <= 4'he;
    wr(8'h50, 8'haa);
    pstrb <= 4'hf;
    rdchk(8'h50, 8'h00);
    for (int i = 0; i < 3; i++) begin
      wr(8'h48, 8'(i));
      wr(8'h4c, 8'(8'h11 * (i + 1)));
    end
    for (int i = 0; i < 3; i++) begin
      wr(8'h48, 8'(i));
      rdchk(8'h4c, 8'(8'h11 * (i + 1)));
    end
    wr(8'h48, 8'h03);
    wr(8'h4c, 8'h55);
    rdchk(8'h4c, 8'h00);
    wr(8'h48, 8'h00);
    rdchk(8'h4c, 8'h11);
    // Period 3, duties 1, 0 and 0x100 on channels 0, 1 and 2.
    // Configuration order.
    wr(8'h50, 8'h03);
    wr(8'h4c, 8'h01);
    for (int i = 1; i < 3; i++) begin
      wr(8'h48, 8'(i));
      wr(8'h4c, 8'h00);
    end
    wr(8'h44, 8'h10);
    for (int d = 0; d < 4; d++) begin
      wr(8'h40, 8'h00);
      wr(8'h48, 8'(d << 4));
      wr(8'h40, 8'h07);
      repeat (80) @(posedge pclk);
      meas(16 << d);
      chk_cnt(cnt[0], 8 << d);
      chk_cnt(cnt[1], 4 << d);
      chk_cnt(cnt[2], 16 << d);
    end
    wr(8'h48, 8'h00);
    wr(8'h4c, 8'h02);
    repeat (12) @(posedge pclk);
    meas(16);
    chk_cnt(cnt[0], 12);
    wr(8'h50, 8'h07);
    repeat (12) @(posedge pclk);
    meas(16);
    chk_cnt(cnt[1], 4);
    wr(8'h40, 8'h00);
    repeat (4) @(posedge pclk);
    meas(8);
    chk_cnt(cnt[2], 0);
    wr(8'h40, 8'h03);
    repeat (20) @(posedge pclk);
    meas(32);
    chk_cnt(cnt[0], 12);
    chk_cnt(cnt[1], 4);
    chk_cnt(cnt[2], 0);
    results;
  end

  // ==========================================================================
  // Watchdog.
  initial begin
    #100000;
    errors++;
    results;
  end
endmodule : tb
